/* logic/scmb_map.vh */
`ifndef SCMB_MAP_VH
`define SCMB_MAP_VH

// Register byte addresses
`define SCMB_ADDR_BUF0 8'h4C
`define SCMB_ADDR_CTL0 8'h4D
`define SCMB_ADDR_MOD0 8'h4E
`define SCMB_ADDR_BUF1 8'h50
`define SCMB_ADDR_CTL1 8'h51
`define SCMB_ADDR_MOD1 8'h52
`define SCMB_ADDR_BRG0 8'h53
`define SCMB_ADDR_BRG1 8'h54
`define SCMB_ADDR_IST 8'h55
`define SCMB_ADDR_IMSK 8'h56

// Mode register fields
`define SCMB_MOD_TB8 7
`define SCMB_MOD_HANDSHAKE_ENABLE 6
`define SCMB_MOD_RXE 5
`define SCMB_MOD_WU 4
`define SCMB_MOD_SM 3:2
`define SCMB_MOD_SC 1:0
`define SCMB_MOD_RST 8'h00

// Transfer modes and clock sources
`define SCMB_SM_IO 2'h0
`define SCMB_SM_U7 2'h1
`define SCMB_SM_U8 2'h2
`define SCMB_SM_U9 2'h3
`define SCMB_SC_TMR 2'h0
`define SCMB_SC_BRG 2'h1
`define SCMB_SC_PHI 2'h2
`define SCMB_SC_EXT 2'h3

// Control register fields
`define SCMB_CTL_RB8 7
`define SCMB_CTL_EVEN 6
`define SCMB_CTL_PE 5
`define SCMB_CTL_OERR 4
`define SCMB_CTL_PERR 3
`define SCMB_CTL_FERR 2
`define SCMB_CTL_SCLKS 1
`define SCMB_CTL_IOC 0
`define SCMB_CTL_RST 8'h00

// Baud generator control fields
`define SCMB_BRG_CK 5:4
`define SCMB_BRG_DIV 3:0
`define SCMB_BRG_RST 6'h00

// Interrupt status bits per channel
`define SCMB_IRQ_BITS 3
`define SCMB_IRQ_RST 6'h00

`endif

/* logic/scmb_top.v */
`timescale 1ns/1ps
`include "scmb_map.vh"
// Overview of operation
// - Two-bit mode picks IO, 7, 8, 9-bit UART
// - UART clock source: timer, baud, phase, pin
// - Wake-up acts only in 9-bit UART mode
// - Handshake bit makes clear-to-send gate sending in UART modes
// - Ninth bit holds parity in 8-bit parity mode
// - Control read clears all error flags together
// - Buffer address: read receive, write transmit
module scmb_top #(
    parameter PRE_WIDTH = 9
) (
    input wire CLK,
    input wire RESET_N,
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    output wire IRQ,
    input wire PRESCALER_RUN,
    input wire TIMER2_TICK,
    input wire [1:0] CTS_N,
    input wire [1:0] SCLK_IN,
    input wire [1:0] RX_VALID,
    input wire [15:0] RX_WORD,
    input wire [1:0] RX_NINTH,
    input wire [1:0] RX_PERR,
    input wire [1:0] RX_FERR,
    input wire [1:0] TX_BUSY,
    output reg [1:0] TX_START,
    output reg [15:0] TX_WORD,
    output reg [1:0] TX_NINTH,
    output reg [1:0] SIO_CLK_EN,
    output wire [3:0] MODE,
    output wire [1:0] RX_ENABLE
);

    reg [PRE_WIDTH-1:0] pre_cnt;
    reg phi1;
    reg [5:0] ist;
    reg [5:0] msk;
    wire [5:0] evt;

    // Prescaler tap tick, shared by both baud generators
    function tap_hit;
        input [PRE_WIDTH-1:0] c;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: tap_hit = &c[1:0];
                2'h1: tap_hit = &c[3:0];
                2'h2: tap_hit = &c[5:0];
                default: tap_hit = &c[7:0];
            endcase
        end
    endfunction

    // Prescaler only counts while its run control is set
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pre_cnt <= {PRE_WIDTH{1'h0}};
            phi1 <= 1'h0;
        end else begin
            phi1 <= ~phi1;
            if (PRESCALER_RUN) begin
                pre_cnt <= pre_cnt + {{(PRE_WIDTH-1){1'h0}}, 1'h1};
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : ch
            localparam [7:0] A_BUF = (i == 0) ? `SCMB_ADDR_BUF0 :
                `SCMB_ADDR_BUF1;
            localparam [7:0] A_CTL = (i == 0) ? `SCMB_ADDR_CTL0 :
                `SCMB_ADDR_CTL1;
            localparam [7:0] A_MOD = (i == 0) ? `SCMB_ADDR_MOD0 :
                `SCMB_ADDR_MOD1;
            localparam [7:0] A_BRG = (i == 0) ? `SCMB_ADDR_BRG0 :
                `SCMB_ADDR_BRG1;

            reg [7:0] mode;
            reg [7:0] ctrl;
            reg [5:0] brg;
            reg [7:0] rx_buf;
            reg rx_full;
            reg [7:0] tx_buf;
            reg tx_pend;
            reg [2:0] cts_s;
            reg cts_st;
            reg [2:0] sclk_s;
            reg sclk_st;
            reg [3:0] bcnt;
            reg bpulse;
            reg half;
            reg next_sio;

            wire wr_buf = WR && (ADDR == A_BUF);
            wire wr_ctl = WR && (ADDR == A_CTL);
            wire wr_mod = WR && (ADDR == A_MOD);
            wire wr_brg = WR && (ADDR == A_BRG);
            wire rd_buf = RD && (ADDR == A_BUF);
            wire rd_ctl = RD && (ADDR == A_CTL);
            wire [1:0] sm = mode[`SCMB_MOD_SM];
            wire uart = (sm != `SCMB_SM_IO);
            // Pin edge counts once the two later stages agree
            wire sclk_rise = (sclk_s[2] == sclk_s[1]) && sclk_s[2] &&
                !sclk_st;
            wire tap = PRESCALER_RUN && tap_hit(pre_cnt, brg[`SCMB_BRG_CK]);
            // Handshake only applies in UART modes
            wire cts_ok = !mode[`SCMB_MOD_HANDSHAKE_ENABLE] || !uart || !cts_st;
            wire start = tx_pend && !TX_BUSY[i] && cts_ok;
            // Wake-up filter ignored outside 9-bit mode
            wire wake = mode[`SCMB_MOD_WU] && (sm == `SCMB_SM_U9);
            wire accept = RX_VALID[i] && mode[`SCMB_MOD_RXE] &&
                !(wake && !RX_NINTH[i]);
            wire ovr = accept && rx_full && !rd_buf;
            wire pe = ctrl[`SCMB_CTL_PE];
            wire par8 = ^tx_buf ^ ~ctrl[`SCMB_CTL_EVEN];
            wire par7 = ^tx_buf[6:0] ^ ~ctrl[`SCMB_CTL_EVEN];
            wire set_p = accept && !ovr && RX_PERR[i];
            wire set_f = accept && !ovr && RX_FERR[i];

            assign evt[3*i +: 3] = {ovr | set_p | set_f, start,
                accept & ~ovr};
            assign MODE[2*i +: 2] = sm;
            assign RX_ENABLE[i] = mode[`SCMB_MOD_RXE];

            // Three-stage pin synchronisers; stage 0 feeds stage 1 only
            always @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    cts_s <= 3'h7;
                    cts_st <= 1'h1;
                    sclk_s <= 3'h0;
                    sclk_st <= 1'h0;
                end else begin
                    cts_s <= {cts_s[1:0], CTS_N[i]};
                    sclk_s <= {sclk_s[1:0], SCLK_IN[i]};
                    if (cts_s[2] == cts_s[1]) begin
                        cts_st <= cts_s[2];
                    end
                    if (sclk_s[2] == sclk_s[1]) begin
                        sclk_st <= sclk_s[2];
                    end
                end
            end

            // Baud generator; a divide field of zero gives sixteen
            always @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    bcnt <= 4'h0;
                    bpulse <= 1'h0;
                    half <= 1'h0;
                end else begin
                    bpulse <= 1'h0;
                    if (tap) begin
                        if (bcnt == (brg[`SCMB_BRG_DIV] - 4'h1)) begin
                            bcnt <= 4'h0;
                            bpulse <= 1'h1;
                        end else begin
                            bcnt <= bcnt + 4'h1;
                        end
                    end
                    if (bpulse) begin
                        half <= ~half;
                    end
                end
            end

            // Bit clock source select
            always @* begin
                next_sio = 1'h0;
                if (!uart) begin
                    next_sio = ctrl[`SCMB_CTL_IOC] ? sclk_rise :
                        (bpulse && half);
                end else begin
                    case (mode[`SCMB_MOD_SC])
                        `SCMB_SC_TMR: next_sio = TIMER2_TICK;
                        `SCMB_SC_BRG: next_sio = bpulse;
                        `SCMB_SC_PHI: next_sio = phi1;
                        `SCMB_SC_EXT: next_sio = sclk_rise;
                        default: next_sio = 1'h0;
                    endcase
                end
            end

            // Mode, control and baud registers
            always @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    mode <= `SCMB_MOD_RST;
                    ctrl <= `SCMB_CTL_RST;
                    brg <= `SCMB_BRG_RST;
                end else begin
                    if (wr_mod) begin
                        mode <= WDATA;
                    end else if (start && pe && sm == `SCMB_SM_U8) begin
                        mode[`SCMB_MOD_TB8] <= par8;
                    end
                    if (wr_brg) begin
                        brg <= WDATA[5:0];
                    end
                    if (wr_ctl) begin
                        ctrl[`SCMB_CTL_EVEN] <= WDATA[`SCMB_CTL_EVEN];
                        ctrl[`SCMB_CTL_PE] <= WDATA[`SCMB_CTL_PE];
                        ctrl[`SCMB_CTL_SCLKS] <= WDATA[`SCMB_CTL_SCLKS];
                        ctrl[`SCMB_CTL_IOC] <= WDATA[`SCMB_CTL_IOC];
                    end
                    // A read clears all three error flags; a new error still lands
                    ctrl[`SCMB_CTL_OERR] <= (ctrl[`SCMB_CTL_OERR] &
                        ~rd_ctl) | ovr;
                    ctrl[`SCMB_CTL_PERR] <= (ctrl[`SCMB_CTL_PERR] &
                        ~rd_ctl) | set_p;
                    ctrl[`SCMB_CTL_FERR] <= (ctrl[`SCMB_CTL_FERR] &
                        ~rd_ctl) | set_f;
                    if (accept && !ovr) begin
                        ctrl[`SCMB_CTL_RB8] <= RX_NINTH[i];
                    end
                end
            end

            // Receive and transmit buffers behind one address
            always @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    rx_buf <= 8'h00;
                    rx_full <= 1'h0;
                    tx_buf <= 8'h00;
                    tx_pend <= 1'h0;
                    TX_START[i] <= 1'h0;
                    TX_WORD[8*i +: 8] <= 8'h00;
                    TX_NINTH[i] <= 1'h0;
                    SIO_CLK_EN[i] <= 1'h0;
                end else begin
                    SIO_CLK_EN[i] <= next_sio;
                    TX_START[i] <= start;
                    // Overrun drops the new word, old one is kept
                    if (accept && !ovr) begin
                        rx_buf <= RX_WORD[8*i +: 8];
                        rx_full <= 1'h1;
                    end else if (rd_buf) begin
                        rx_full <= 1'h0;
                    end
                    if (wr_buf) begin
                        tx_buf <= WDATA;
                        tx_pend <= 1'h1;
                    end else if (start) begin
                        tx_pend <= 1'h0;
                    end
                    if (start) begin
                        TX_WORD[8*i +: 8] <= tx_buf;
                        if (pe && sm == `SCMB_SM_U7) begin
                            TX_WORD[8*i+7] <= par7;
                        end
                        TX_NINTH[i] <= (pe && sm == `SCMB_SM_U8) ?
                            par8 : mode[`SCMB_MOD_TB8];
                    end
                end
            end
        end
    endgenerate

    // Interrupt status, write one to clear; set wins over clear
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ist <= `SCMB_IRQ_RST;
            msk <= `SCMB_IRQ_RST;
        end else begin
            if (WR && ADDR == `SCMB_ADDR_IMSK) begin
                msk <= WDATA[5:0];
            end
            if (WR && ADDR == `SCMB_ADDR_IST) begin
                ist <= (ist & ~WDATA[5:0]) | evt;
            end else begin
                ist <= ist | evt;
            end
        end
    end

    assign IRQ = |(ist & msk);

    // Read data valid only in the cycle after the strobe
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= 8'h00;
        end else if (!RD) begin
            RDATA <= 8'h00;
        end else begin
            case (ADDR)
                `SCMB_ADDR_BUF0: RDATA <= ch[0].rx_buf;
                `SCMB_ADDR_CTL0: RDATA <= ch[0].ctrl;
                `SCMB_ADDR_MOD0: RDATA <= ch[0].mode;
                `SCMB_ADDR_BUF1: RDATA <= ch[1].rx_buf;
                `SCMB_ADDR_CTL1: RDATA <= ch[1].ctrl;
                `SCMB_ADDR_MOD1: RDATA <= ch[1].mode;
                `SCMB_ADDR_BRG0: RDATA <= {2'h0, ch[0].brg};
                `SCMB_ADDR_BRG1: RDATA <= {2'h0, ch[1].brg};
                `SCMB_ADDR_IST: RDATA <= {2'h0, ist};
                `SCMB_ADDR_IMSK: RDATA <= {2'h0, msk};
                default: RDATA <= 8'h00;
            endcase
        end
    end

endmodule // scmb_top

/* tb/scmb_checker.sv */
`timescale 1ns/1ps
`include "scmb_map.vh"
module scmb_checker (
    input wire CLK,
    input wire RESET_N,
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [7:0] RDATA,
    input wire IRQ,
    input wire [1:0] RX_VALID,
    input wire [1:0] TX_BUSY,
    input wire [1:0] TX_START,
    input wire [15:0] TX_WORD,
    input wire [3:0] MODE,
    input wire [1:0] RX_ENABLE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    wire wm0 = WR && ADDR == `SCMB_ADDR_MOD0;
    wire wm1 = WR && ADDR == `SCMB_ADDR_MOD1;
    wire rc0 = RD && ADDR == `SCMB_ADDR_CTL0;
    // Two control reads in a row, no word landing under the first
    sequence s_ctl_pair; rc0 && !RX_VALID[0] ##1 rc0; endsequence
    // Idle-mode buffer write, shifter free for two cycles
    sequence s_io_wr;
        WR && ADDR == `SCMB_ADDR_BUF0 && MODE[1:0] == `SCMB_SM_IO
            && !TX_BUSY[0] ##1 !TX_BUSY[0];
    endsequence
    property p_rdata_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("rdata off slot");
    property p_mode_hold; !$past(wm0) |-> $stable(MODE[1:0]); endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode moved");
    property p_mode_load; wm0 |=> MODE[1:0] == $past(WDATA[3:2])
        && RX_ENABLE[0] == $past(WDATA[5]); endproperty
    a_mode_load: assert property (p_mode_load)
        else $error("mode load");
    property p_ch1_load; wm1 |=> MODE[3:2] == $past(WDATA[3:2])
        && RX_ENABLE[1] == $past(WDATA[5]); endproperty
    a_ch1_load: assert property (p_ch1_load)
        else $error("ch1 mode load");
    property p_busy_hold; TX_BUSY[0] |=> !TX_START[0]; endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("start while busy");
    property p_tx_io; s_io_wr |=> TX_START[0]
        && TX_WORD[7:0] == $past(WDATA, 2); endproperty
    a_tx_io: assert property (p_tx_io)
        else $error("tx hand-over");
    property p_err_clr; s_ctl_pair |=> RDATA[4:2] == 3'h0; endproperty
    a_err_clr: assert property (p_err_clr)
        else $error("errors kept");
    property p_irq_rise; $rose(IRQ) |-> $past(WR)
        || $past(RX_VALID != 2'h0) || TX_START != 2'h0; endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("irq without cause");
endmodule // scmb_checker

bind scmb_top scmb_checker i_scmb_checker (.CLK(CLK), .RESET_N(RESET_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .IRQ(IRQ), .RX_VALID(RX_VALID), .TX_BUSY(TX_BUSY),
    .TX_START(TX_START), .TX_WORD(TX_WORD), .MODE(MODE),
    .RX_ENABLE(RX_ENABLE));

/* tb/scmb_partner.sv */
`timescale 1ns/1ps
module scmb_partner #(
    parameter BUSY = 6
) (
    input wire clk,
    input wire rst_n,
    input wire [1:0] tx_start,
    input wire [15:0] tx_word,
    input wire [1:0] tx_ninth,
    input wire [1:0] err,
    output wire [1:0] busy,
    output wire [1:0] rx_valid,
    output wire [15:0] rx_word,
    output wire [1:0] rx_ninth,
    output wire [1:0] rx_err
);
    genvar g;
    // Far shifter: busy for a frame, then echoes the word back
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            reg [7:0] w;
            reg n9, v;
            integer cnt;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt <= 0;
                    v <= 1'b0;
                    w <= 8'h00;
                    n9 <= 1'b0;
                end else begin
                    v <= (cnt == 1);
                    if (tx_start[g]) begin
                        cnt <= BUSY;
                        w <= tx_word[8 * g +: 8];
                        n9 <= tx_ninth[g];
                    end else if (cnt != 0)
                        cnt <= cnt - 1;
                end
            end
            assign busy[g] = (cnt != 0);
            // Word delivered for one cycle as the frame ends
            assign rx_valid[g] = v;
            // Stale data inverted so nobody relies on it
            assign rx_word[8 * g +: 8] = v ? w : ~w;
            assign rx_ninth[g] = v ? n9 : ~n9;
            assign rx_err[g] = v & err[g];
        end
    endgenerate
endmodule // scmb_partner

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "scmb_map.vh"
module testbench;
    reg CLK, RESET_N, WR, RD, PRESCALER_RUN, TIMER2_TICK, ok, tn;
    reg [7:0] ADDR, WDATA, r1, r2, tw_w;
    reg [1:0] CTS_N, SCLK_IN, err;
    reg [31:0] seed;
    wire [7:0] RDATA;
    wire [15:0] RXW, TXW;
    wire [3:0] MODE;
    wire IRQ;
    wire [1:0] RXV, RXN, PE, BSY, TXS, TXN, SIO, RECEIVE_ENABLE_BIT;
    integer n_fail, n_compared, cyc, n_sio, i, s0;
    localparam B0 = `SCMB_ADDR_BUF0, M0 = `SCMB_ADDR_MOD0;
    scmb_top i_scmb_top (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
        .PRESCALER_RUN(PRESCALER_RUN), .TIMER2_TICK(TIMER2_TICK),
        .CTS_N(CTS_N), .SCLK_IN(SCLK_IN), .RX_VALID(RXV), .RX_WORD(RXW),
        .RX_NINTH(RXN), .RX_PERR(PE), .RX_FERR(PE), .TX_BUSY(BSY),
        .TX_START(TXS), .TX_WORD(TXW), .TX_NINTH(TXN),
        .SIO_CLK_EN(SIO), .MODE(MODE), .RX_ENABLE(RECEIVE_ENABLE_BIT));
    scmb_partner i_scmb_partner (.clk(CLK), .rst_n(RESET_N),
        .tx_start(TXS), .tx_word(TXW), .tx_ninth(TXN), .err(err),
        .busy(BSY), .rx_valid(RXV), .rx_word(RXW), .rx_ninth(RXN),
        .rx_err(PE));
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function par(input [7:0] v, input even);
        par = even ? ^v : ~^v;
    endfunction
    // Bit clock pulses over 256 cycles per source
    function integer sio_exp(input integer s);
        sio_exp = s == 0 ? 32 : s == 1 ? 8 : s == 2 ? 128 : s == 4 ? 4 : 16;
    endfunction
    task chk(input [15:0] got, input [15:0] exp, input string what);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %0s expected %h seen %h", what, exp, got);
        end
    endtask
    task conclude;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // A spare edge after each strobe keeps drivers from colliding
    task wr(input [7:0] a, input [7:0] v);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask
    // One-cycle read; data taken once settled in the cycle after
    task rd(input [7:0] a);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 r1 = RDATA;
        @(posedge CLK);
    endtask
    // Two reads back to back, strobe held up across both
    task rd2(input [7:0] a);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        #1 r1 = RDATA;
        @(posedge CLK);
        RD <= 1'b0;
        #1 r2 = RDATA;
        @(posedge CLK);
    endtask
    // Bounded wait for the hand-over, sampled mid-cycle
    task tw;
        for (s0 = 0; s0 < 40 && TXS[0] !== 1'b1; s0 = s0 + 1)
            @(negedge CLK);
        ok = TXS[0];
        tw_w = TXW[7:0];
        tn = TXN[0];
        @(posedge CLK);
    endtask
    task tx(input [7:0] v);
        wr(B0, v);
        tw;
    endtask
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // Source stimulus, pulse count and hang guard
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        TIMER2_TICK <= (cyc % 8 == 0);
        if (cyc % 8 == 0) SCLK_IN <= ~SCLK_IN;
        n_sio <= n_sio + SIO[0];
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            conclude;
        end
    end
    initial begin
        {WR, RD, ADDR, WDATA, TIMER2_TICK, SCLK_IN, err, RESET_N} = 0;
        {n_fail, n_compared, cyc, n_sio} = 0;
        CTS_N = 2'b11;
        PRESCALER_RUN = 1'b1;
        seed = 32'h0001_7F20;
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        for (i = 0; i < 11; i = i + 1) begin
            rd(8'h4C + i[7:0]);
            chk(r1, 0, "reset");
        end
        // Every transfer mode on both channels
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            r2 = {seed[7:4], i[1:0], seed[1:0]};
            wr(M0 + (i[2] ? 8'h04 : 8'h00), r2);
            rd(M0 + (i[2] ? 8'h04 : 8'h00));
            chk(r1, r2, "mode");
            chk(MODE[2 * i[2] +: 2], i[1:0], "mode pin");
        end
        // Word out in idle mode, echoed back, raises the interrupt
        wr(M0, 8'h20);
        wr(`SCMB_ADDR_IMSK, 8'h01);
        seed = xs(seed);
        tx(seed[7:0]);
        chk(tw_w, seed[7:0], "tx word");
        rd(B0);
        chk(r1, 0, "rx early");
        for (i = 0; i < 40 && IRQ !== 1'b1; i = i + 1) @(negedge CLK);
        chk(IRQ, 1, "irq");
        @(posedge CLK);
        rd(B0);
        chk(r1, seed[7:0], "rx word");
        wr(`SCMB_ADDR_IST, 8'h3F);
        @(negedge CLK);
        chk(IRQ, 0, "irq clear");
        @(posedge CLK);
        // Handshake holds the word until clear-to-send falls
        wr(M0, 8'h48);
        tx(8'h5A);
        chk(ok, 0, "cts hold");
        CTS_N <= 2'b10;
        tw;
        chk(ok, 1, "cts go");
        wr(M0, 8'h08);
        CTS_N <= 2'b11;
        tx(8'hA5);
        chk(ok, 1, "no handshake");
        // Parity in the ninth bit (8-bit) or in bit 7 (7-bit)
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            wr(`SCMB_ADDR_CTL0, i[0] ? 8'h20 : 8'h60);
            wr(M0, i[1] ? 8'h04 : 8'h08);
            tx(seed[7:0]);
            rd(M0);
            r2 = {par(seed[6:0], !i[0]), seed[6:0]};
            if (i[1]) chk(tw_w, r2, "par7");
            else chk({tn, r1[7]}, {2{par(seed[7:0], !i[0])}},
                "par8");
        end
        wr(`SCMB_ADDR_CTL0, 8'h00);
        wr(M0, 8'h8C);
        tx(8'h3C);
        chk(tn, 1, "ninth");
        // Let that echo pass before receive is enabled
        repeat (20) @(posedge CLK);
        // Wake-up drops ninth-zero words in 9-bit mode only
        wr(`SCMB_ADDR_IMSK, 8'h00);
        wr(M0, 8'h3C);
        tx(8'h11);
        repeat (20) @(posedge CLK);
        rd(`SCMB_ADDR_IST);
        chk(r1[0], 0, "wake drop");
        err <= 2'b01;
        wr(M0, 8'h34);
        tx(8'h22);
        repeat (20) @(posedge CLK);
        chk(IRQ, 0, "masked");
        rd2(`SCMB_ADDR_CTL0);
        chk({r1[3:2], r2[4:2]}, 5'h18, "err clear");
        rd(`SCMB_ADDR_IST);
        chk(r1[2:0], 3'h7, "wake off");
        // Divide 8, never 1, and only with no frame moving
        wr(`SCMB_ADDR_BRG0, 8'h08);
        // Then the four UART sources, then IO mode: baud halved, then the pin
        for (i = 0; i < 6; i = i + 1) begin
            wr(`SCMB_ADDR_CTL0, {7'h00, i[0]});
            wr(M0, i[2] ? 8'h00 : 8'h08 | i[7:0]);
            s0 = n_sio;
            repeat (256) @(posedge CLK);
            s0 = n_sio - s0 - sio_exp(i);
            chk(s0 * s0 <= 1 ? 0 : s0, 0, "bit clock");
        end
        conclude;
    end
endmodule // testbench
